// ### rtl/tcpw_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tcpw_timer (
    // Clock and reset
    input wire logic  clk,
    input wire logic  rst_b,
    // Register port
    input wire logic  [7:0] reg_addr,
    input wire logic  [7:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    output logic      [7:0] reg_rdata,
    // Source rate enables
    input wire logic  fcpu_en,
    input wire logic  fhosc_en,
    // Comparator trigger
    input wire logic  cmp_out,
    input wire logic  cmp_rise_sel,
    input wire logic  comparator_trigger_select,
    // Output pin and flag
    output logic      tc_pin,
    output logic      tc_pin_oe,
    output logic      overflow_flag
);
    import tcpw_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] count_q;
    logic [7:0] reload_hold_q;
    logic [7:0] reload_act_q;
    logic [7:0] duty_q;
    logic       flag_q;
    logic       busy_q;
    logic       busy_d;
    logic       pwm_act_q;
    logic       pwm_act_d;
    logic       req_last_q;
    logic [7:0] rdata_q;
    logic       pin_q;
    logic       pin_oe_q;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic wr_count;
    logic wr_reload;
    logic wr_duty;
    logic wr_mode;
    logic wr_status;
    logic run;
    logic pulse_mode;
    logic phase;
    logic req;
    logic tick;
    logic cmp_edge;
    logic cnt_go;
    logic ovf;
    logic trig;
    logic en_rise;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wr_count  = reg_wr && hit(reg_addr, TCPW_ADDR_COUNT);
    assign wr_reload = reg_wr && hit(reg_addr, TCPW_ADDR_RELOAD);
    assign wr_duty   = reg_wr && hit(reg_addr, TCPW_ADDR_DUTY);
    assign wr_mode   = reg_wr && hit(reg_addr, TCPW_ADDR_MODE);
    assign wr_status = reg_wr && hit(reg_addr, TCPW_ADDR_STATUS);

    assign run        = mode_q[TCPW_MODE_RUN];
    assign pulse_mode = mode_q[TCPW_MODE_PULSE];
    assign phase      = mode_q[TCPW_MODE_PHASE];
    assign req        = mode_q[TCPW_MODE_REQ];

    // ------------------------------------------------------------
    // Prescaler and comparator edge
    // ------------------------------------------------------------
    tcpw_tick_if tk ();

    assign tk.fcpu_en  = fcpu_en;
    assign tk.fhosc_en = fhosc_en;
    assign tk.src_sel  = mode_q[TCPW_MODE_SRC];
    assign tk.rate     = mode_q[TCPW_MODE_RATE_HI:TCPW_MODE_RATE_LO];
    assign tk.run      = run && (!pulse_mode || busy_q);
    assign tick        = tk.tick;

    tcpw_prescale u_presc (
        .clk   (clk),
        .rst_b (rst_b),
        .tk    (tk.src)
    );

    tcpw_cmp_edge u_edge (
        .clk        (clk),
        .rst_b      (rst_b),
        .cmp_in     (cmp_out),
        .rise_sel   (cmp_rise_sel),
        .edge_pulse (cmp_edge)
    );

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    assign cnt_go = run && tick && (!pulse_mode || busy_q);
    assign ovf    = cnt_go && (count_q == TCPW_COUNT_TOP);

    // Software write wins over the count step in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= TCPW_RST_BYTE;
        end else if (wr_count) begin
            count_q <= reg_wdata;
        end else if (ovf) begin
            count_q <= reload_hold_q;
        end else if (cnt_go) begin
            count_q <= count_q + 8'h0001;
        end
    end

    // Holding buffer moves to active only at overflow
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reload_hold_q <= TCPW_RST_BYTE;
            reload_act_q  <= TCPW_RST_BYTE;
        end else begin
            if (wr_reload) begin
                reload_hold_q <= reg_wdata;
            end
            if (ovf) begin
                reload_act_q <= reload_hold_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            duty_q <= TCPW_RST_BYTE;
        end else if (wr_duty) begin
            duty_q <= reg_wdata;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (ovf) begin
            flag_q <= 1'b1;
        end else if (wr_status && reg_wdata[TCPW_STAT_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode register and pulse sequencing
    // ------------------------------------------------------------
    // Software write of the request bit wins over the hardware clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= TCPW_RST_BYTE;
        end else if (wr_mode) begin
            mode_q <= reg_wdata;
        end else if (pulse_mode && !comparator_trigger_select && busy_q && ovf) begin
            mode_q[TCPW_MODE_REQ] <= 1'b0;
        end
    end

    // Comparator edges during a pulse are ignored
    assign trig = comparator_trigger_select ? cmp_edge : req;

    always_comb begin
        busy_d = busy_q;
        if (!run || !pulse_mode) begin
            busy_d = 1'b0;
        end else if (busy_q) begin
            if (ovf) begin
                busy_d = 1'b0;
            end else if (!comparator_trigger_select && !req) begin
                busy_d = 1'b0;
            end
        end else if (trig) begin
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    // ------------------------------------------------------------
    // PWM waveform
    // ------------------------------------------------------------
    assign en_rise = req && !req_last_q;

    // Next count compared too, so the pin falls with the step onto duty
    always_comb begin
        pwm_act_d = pwm_act_q;
        if (en_rise || ovf) begin
            pwm_act_d = 1'b1;
        end else if (run && count_q == duty_q) begin
            pwm_act_d = 1'b0;
        end else if (cnt_go && !wr_count && (count_q + 8'h0001) == duty_q) begin
            pwm_act_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_act_q  <= 1'b0;
            req_last_q <= 1'b0;
        end else begin
            pwm_act_q  <= pwm_act_d;
            req_last_q <= req && !pulse_mode;
        end
    end

    // Pin is released to general purpose between pulses and, outside pulse mode, while the request bit is clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
        end else if (pulse_mode) begin
            pin_q    <= !phase;
            pin_oe_q <= busy_d;
        end else begin
            pin_q    <= pwm_act_d ? !phase : phase;
            pin_oe_q <= req;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Reload is write-only and reads zero, as do unmapped offsets
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= TCPW_RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                TCPW_ADDR_COUNT:  rdata_q <= count_q;
                TCPW_ADDR_DUTY:   rdata_q <= duty_q;
                TCPW_ADDR_MODE:   rdata_q <= mode_q;
                TCPW_ADDR_STATUS: rdata_q <= {7'h00, flag_q};
                default:          rdata_q <= TCPW_RST_BYTE;
            endcase
        end else begin
            rdata_q <= TCPW_RST_BYTE;
        end
    end

    assign reg_rdata     = rdata_q;
    assign tc_pin        = pin_q;
    assign tc_pin_oe     = pin_oe_q;
    assign overflow_flag = flag_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_HOLD_STOPPED: assert property (
        (!run && !wr_count) |=> $stable(count_q))
        else $error("counter moved while stopped");

    AST_STEP_ONE: assert property (
        (cnt_go && !ovf && !wr_count) |=> count_q == $past(count_q) + 8'h0001)
        else $error("counter did not step by one");

    AST_FLAG_SET: assert property (
        ovf |=> flag_q ##1 (flag_q || $past(wr_status)))
        else $error("overflow flag not set or lost");

    AST_RELOAD: assert property (
        (ovf && !wr_count) |=> count_q == $past(reload_hold_q))
        else $error("counter not reloaded at overflow");

    AST_DOUBLE_BUF: assert property (
        (wr_reload && !ovf) |=> reload_act_q == $past(reload_act_q))
        else $error("active reload changed without overflow");

    AST_PWM_PIN: assert property (
        (!pulse_mode && !wr_mode) |=> tc_pin_oe == req)
        else $error("pin routing does not follow request bit");

    AST_PWM_DUTY: assert property (
        (!pulse_mode && run && count_q == duty_q && !ovf && !en_rise && !wr_mode)
        |=> tc_pin == phase)
        else $error("duty match did not end active phase");

    AST_PWM_WRAP: assert property (
        (!pulse_mode && ovf && !wr_mode) |=> (pwm_act_q && tc_pin == !phase))
        else $error("wrap did not restart active phase");

    AST_PULSE_END: assert property (
        (pulse_mode && busy_q && ovf && !wr_mode) |=> (!busy_q && !tc_pin_oe))
        else $error("pulse did not end at overflow");

    AST_REQ_CLEAR: assert property (
        (pulse_mode && !comparator_trigger_select && busy_q && ovf && !wr_mode)
        |=> !req)
        else $error("request bit not cleared at pulse end");

    AST_CMP_START: assert property (
        (run && pulse_mode && comparator_trigger_select && !busy_q && cmp_edge
         && !wr_mode) |=> (busy_q && tc_pin_oe && tc_pin == !phase))
        else $error("comparator edge did not start pulse");

    COV_PWM_WRAP:  cover property (!pulse_mode && req && ovf);
    COV_SW_PULSE:  cover property (pulse_mode && !comparator_trigger_select && busy_q && ovf);
    COV_CMP_PULSE: cover property (pulse_mode && comparator_trigger_select && !busy_q && cmp_edge);
    COV_FLAG_RACE: cover property (ovf && wr_status && reg_wdata[TCPW_STAT_FLAG]);
endmodule
`default_nettype wire

// ### rtl/tcpw_pkg.sv
// Function
// - Timer counts only while the run bit (mode bit 7) is one.
// - Prescaler code 000 divides by 256, each step halves, 111 divides by 2.
// - Source clock select 0 feeds instruction clock, 1 feeds oscillator clock.
// - Phase 0 gives high active output, 1 low; pin released after pulse.
// - Pulse mode bit one makes the block a one-shot pulse generator.
// - Outside pulse mode the request bit routes PWM to the pin.
// - In pulse mode with trigger select 0, request bit starts or stops pulse; hardware clears it.
// - Eight-bit counter overflow sets a sticky flag until software clears it.
// - Every overflow reloads the counter from the holding buffer reload value.
// - Reload writes land in a holding buffer, moved to active at overflow.
// - PWM active phase ends when counter equals duty compare value.
// - PWM period follows reload value, duty follows duty compare register.
// - Trigger select 0 uses request bit, 1 uses comparator output edge.
// - PWM goes active when enabled and again at each counter wrap.
// - Software-trigger pulse: wait, count, stop at overflow, clear request, flag.
// - Comparator-trigger pulse: start on edge, stop at overflow, flag, reload.
`default_nettype none
package tcpw_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TCPW_ADDR_COUNT  = 8'h00b5;
    localparam logic [7:0] TCPW_ADDR_RELOAD = 8'h00b6;
    localparam logic [7:0] TCPW_ADDR_DUTY   = 8'h00b7;
    localparam logic [7:0] TCPW_ADDR_MODE   = 8'h00da;
    localparam logic [7:0] TCPW_ADDR_STATUS = 8'h00db;
    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int TCPW_MODE_RUN    = 7;
    localparam int TCPW_MODE_RATE_HI = 6;
    localparam int TCPW_MODE_RATE_LO = 4;
    localparam int TCPW_MODE_SRC    = 3;
    localparam int TCPW_MODE_PHASE  = 2;
    localparam int TCPW_MODE_PULSE  = 1;
    localparam int TCPW_MODE_REQ    = 0;
    localparam int TCPW_STAT_FLAG   = 0;
    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0] TCPW_RST_BYTE   = 8'h0000;
    localparam logic [7:0] TCPW_COUNT_TOP  = 8'h00ff;
    localparam logic [7:0] TCPW_PRESC_FULL = 8'h00ff;
endpackage
`default_nettype wire

// ### rtl/tcpw_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcpw_tick_if;
    logic       fcpu_en;
    logic       fhosc_en;
    logic       src_sel;
    logic [2:0] rate;
    logic       run;
    logic       tick;
    modport src (input fcpu_en, input fhosc_en, input src_sel, input rate, input run,
                 output tick);
    modport sink (output fcpu_en, output fhosc_en, output src_sel, output rate,
                  output run, input tick);
endinterface
`default_nettype wire

// ### rtl/tcpw_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tcpw_prescale (
    // Clock and reset
    input wire logic  clk,
    input wire logic  rst_b,
    // Tick link
    tcpw_tick_if.src  tk
);
    import tcpw_pkg::*;

    logic [7:0] presc_q;
    logic [7:0] mask;
    logic       src_en;

    // Low bits all ones marks one full divide period
    assign mask   = TCPW_PRESC_FULL >> tk.rate;
    assign src_en = tk.src_sel ? tk.fhosc_en : tk.fcpu_en;
    assign tk.tick = tk.run && src_en && ((presc_q & mask) == mask);

    // Cleared while stopped so the first interval is whole
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_q <= TCPW_RST_BYTE;
        end else if (!tk.run) begin
            presc_q <= TCPW_RST_BYTE;
        end else if (src_en) begin
            presc_q <= presc_q + 8'h0001;
        end
    end
endmodule
`default_nettype wire

// ### rtl/tcpw_cmp_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tcpw_cmp_edge (
    // Clock and reset
    input wire logic  clk,
    input wire logic  rst_b,
    // Comparator side
    input wire logic  cmp_in,
    input wire logic  rise_sel,
    // Event out
    output logic      edge_pulse
);
    logic sync1_q;
    logic sync2_q;
    logic last_q;

    // Two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q  <= 1'b0;
        end else begin
            sync1_q <= cmp_in;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
        end
    end

    assign edge_pulse = rise_sel ? (sync2_q && !last_q) : (!sync2_q && last_q);
endmodule
`default_nettype wire

// ### tb/tcpw_load.sv
`timescale 1ns/1ps
`default_nettype none
module tcpw_load (
    // Clock and reset
    input wire logic         clk,
    input wire logic         rst_b,
    // Pin seen by the load
    input wire logic         tc_pin,
    input wire logic         tc_pin_oe,
    // Measurements
    output logic             pin_lvl,
    output logic      [15:0] hi_run,
    output logic      [15:0] lo_run,
    output logic      [15:0] pulse_len
);
    logic [15:0] run_q;
    logic [15:0] oe_run_q;
    logic        prev_q;
    logic        oe_prev_q;

    // Pull-up holds the line high once the block lets go
    assign pin_lvl = tc_pin_oe ? tc_pin : 1'b1;

    // -------------------------------------------------
    // Level run lengths while the block owns the pin
    // -------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q  <= '0;
            prev_q <= 1'b0;
            hi_run <= '0;
            lo_run <= '0;
        end else if (!tc_pin_oe) begin
            run_q <= '0;
        end else if (run_q != 0 && pin_lvl !== prev_q) begin
            if (prev_q) begin
                hi_run <= run_q;
            end else begin
                lo_run <= run_q;
            end
            run_q  <= 16'h0001;
            prev_q <= pin_lvl;
        end else begin
            run_q  <= run_q + 16'h0001;
            prev_q <= pin_lvl;
        end
    end

    // -------------------------------------------------
    // Length of each ownership window (pulse width)
    // -------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_run_q  <= '0;
            oe_prev_q <= 1'b0;
            pulse_len <= '0;
        end else begin
            oe_prev_q <= tc_pin_oe;
            if (tc_pin_oe) begin
                oe_run_q <= oe_run_q + 16'h0001;
            end else begin
                oe_run_q <= '0;
            end
            if (oe_prev_q && !tc_pin_oe) begin
                pulse_len <= oe_run_q;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/test_tc0_timer_pwm_pulse_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_tc0_timer_pwm_pulse_regs;
    import tcpw_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = '0;
    logic [7:0]  reg_wdata = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        fcpu_en = 1'b1;
    logic        fhosc_en = 1'b0;
    logic        cmp_out = 1'b0;
    logic        cmp_rise_sel = 1'b1;
    logic        trig_sel = 1'b0;
    logic        tc_pin;
    logic        tc_pin_oe;
    logic        overflow_flag;
    logic        pin_lvl;
    logic [15:0] hi_run;
    logic [15:0] lo_run;
    logic [15:0] pulse_len;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          d;

    always #2.5 clk = ~clk;

    tcpw_timer u_tcpw_timer (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fcpu_en(fcpu_en), .fhosc_en(fhosc_en), .cmp_out(cmp_out),
        .cmp_rise_sel(cmp_rise_sel), .comparator_trigger_select(trig_sel),
        .tc_pin(tc_pin), .tc_pin_oe(tc_pin_oe), .overflow_flag(overflow_flag));
    tcpw_load u_tcpw_load (.clk(clk), .rst_b(rst_b), .tc_pin(tc_pin),
        .tc_pin_oe(tc_pin_oe), .pin_lvl(pin_lvl), .hi_run(hi_run), .lo_run(lo_run),
        .pulse_len(pulse_len));

    // -------------------------------------------------
    // Shared tasks
    // -------------------------------------------------
    task automatic close_out();
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        // Read data stand for this one cycle; taken at its closing edge
        @(posedge clk);
        chk(what, {8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // Bounded wait; a missing overflow counts as a mismatch
    task automatic wait_flag();
        int i;
        i = 0;
        while (overflow_flag !== 1'b1 && i < 2000) begin
            @(posedge clk);
            i++;
        end
        chk("overflow_flag", {15'h0000, overflow_flag}, 16'h0001);
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            close_out();
        end
    end

    // -------------------------------------------------
    // Main sequence
    // -------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(TCPW_ADDR_COUNT, 8'h00, "count reset");
        rd(TCPW_ADDR_RELOAD, 8'h00, "reload reads zero");
        rd(TCPW_ADDR_DUTY, 8'h00, "duty reset");
        rd(TCPW_ADDR_MODE, 8'h00, "mode reset");
        rd(8'h00, 8'h00, "unmapped read");
        wr(TCPW_ADDR_DUTY, 8'ha5);
        rd(TCPW_ADDR_DUTY, 8'ha5, "duty rw");
        // Rate table on both sources; only the selected enable pulses
        for (int s = 0; s < 2; s++) begin
            fcpu_en  <= (s == 0);
            fhosc_en <= (s == 1);
            for (int r = 0; r < 8; r++) begin
                d = 256 >> r;
                wr(TCPW_ADDR_COUNT, 8'h00);
                wr(TCPW_ADDR_MODE, 8'(8'h80 | (r << 4) | (s << 3)));
                // Count is sampled half a divide after the third tick
                repeat (3 * d + d / 2 - 2) @(posedge clk);
                rd(TCPW_ADDR_COUNT, 8'h03, "ticks per divide");
                wr(TCPW_ADDR_MODE, 8'h00);
                if (r < 6) begin
                    repeat (2 * d) @(posedge clk);
                    rd(TCPW_ADDR_COUNT, 8'h03, "count held stopped");
                end
            end
        end
        // Unselected source must not clock the counter
        fcpu_en  <= 1'b1;
        fhosc_en <= 1'b0;
        wr(TCPW_ADDR_COUNT, 8'h00);
        wr(TCPW_ADDR_MODE, 8'hf8);
        repeat (40) @(posedge clk);
        rd(TCPW_ADDR_COUNT, 8'h00, "other source ignored");
        // Overflow, reload and a new interval through the holding buffer
        wr(TCPW_ADDR_MODE, 8'h00);
        wr(TCPW_ADDR_COUNT, 8'hfe);
        wr(TCPW_ADDR_RELOAD, 8'hfe);
        wr(TCPW_ADDR_MODE, 8'h80);
        wr(TCPW_ADDR_RELOAD, 8'h40);
        chk("flag before overflow", {15'h0000, overflow_flag}, 16'h0000);
        wait_flag();
        rd(TCPW_ADDR_COUNT, 8'h40, "count reloaded");
        wr(TCPW_ADDR_MODE, 8'h00);
        repeat (20) @(posedge clk);
        rd(TCPW_ADDR_STATUS, 8'h01, "flag sticky");
        wr(TCPW_ADDR_STATUS, 8'h01);
        rd(TCPW_ADDR_STATUS, 8'h00, "flag cleared");
        // PWM: period 16 ticks, active 4 ticks, two cycles a tick
        wr(TCPW_ADDR_COUNT, 8'hf0);
        wr(TCPW_ADDR_RELOAD, 8'hf0);
        wr(TCPW_ADDR_DUTY, 8'hf4);
        wr(TCPW_ADDR_MODE, 8'hf1);
        repeat (110) @(posedge clk);
        chk("pwm oe", {15'h0000, tc_pin_oe}, 16'h0001);
        chk("pwm high run", hi_run, 16'h0008);
        chk("pwm low run", lo_run, 16'h0018);
        wr(TCPW_ADDR_MODE, 8'hf5);
        repeat (110) @(posedge clk);
        chk("inverse high run", hi_run, 16'h0018);
        chk("inverse low run", lo_run, 16'h0008);
        wr(TCPW_ADDR_MODE, 8'hf0);
        repeat (4) @(posedge clk);
        chk("pwm released", {15'h0000, tc_pin_oe}, 16'h0000);
        chk("pulled line", {15'h0000, pin_lvl}, 16'h0001);
        // Software-trigger pulse of 8 ticks
        wr(TCPW_ADDR_MODE, 8'h00);
        wr(TCPW_ADDR_STATUS, 8'h01);
        wr(TCPW_ADDR_COUNT, 8'hf8);
        wr(TCPW_ADDR_RELOAD, 8'hf8);
        wr(TCPW_ADDR_MODE, 8'hf2);
        repeat (40) @(posedge clk);
        rd(TCPW_ADDR_COUNT, 8'hf8, "pulse waits for trigger");
        chk("no pulse yet", {15'h0000, tc_pin_oe}, 16'h0000);
        wr(TCPW_ADDR_MODE, 8'hf3);
        repeat (4) @(posedge clk);
        chk("pulse level", {14'h0000, tc_pin_oe, tc_pin}, 16'h0003);
        wait_flag();
        repeat (3) @(posedge clk);
        chk("pulse width", {15'h0000, pulse_len >= 15 && pulse_len <= 17}, 16'h0001);
        rd(TCPW_ADDR_MODE, 8'hf2, "request cleared");
        rd(TCPW_ADDR_COUNT, 8'hf8, "pulse reload");
        // Comparator edges: ignored under select 0, start a pulse under select 1
        wr(TCPW_ADDR_STATUS, 8'h01);
        cmp_out <= 1'b1;
        repeat (10) @(posedge clk);
        cmp_out <= 1'b0;
        repeat (10) @(posedge clk);
        chk("edge ignored", {15'h0000, overflow_flag | tc_pin_oe}, 16'h0000);
        trig_sel <= 1'b1;
        repeat (4) @(posedge clk);
        cmp_out <= 1'b1;
        repeat (8) @(posedge clk);
        chk("edge pulse", {15'h0000, tc_pin_oe}, 16'h0001);
        wait_flag();
        repeat (3) @(posedge clk);
        chk("edge width", {15'h0000, pulse_len >= 15 && pulse_len <= 17}, 16'h0001);
        rd(TCPW_ADDR_COUNT, 8'hf8, "edge reload");
        // Falling-edge select on the same comparator line
        cmp_rise_sel <= 1'b0;
        wr(TCPW_ADDR_STATUS, 8'h01);
        cmp_out <= 1'b0;
        wait_flag();
        repeat (3) @(posedge clk);
        chk("fall width", {15'h0000, pulse_len >= 15 && pulse_len <= 17}, 16'h0001);
        close_out();
    end
endmodule
`default_nettype wire
